// File: rtl/mcsu_regs.vh
// constants, register map and field layout of the memory and peripheral select unit
// Operation
// - after reset upper select is on for F0000h-FFFFFh, external ready, three waits
// - reset upper select decodes the first fetch address FFFF0h
// - upper lower boundary programmable, 64K to 512K, always ends at top
// - low select off after reset, enabled by any access to its register
// - four midrange selects, one relocatable block outside upper, low, peripheral
// - midrange may overlap peripheral selects that sit in I/O space
// - block size from auxiliary register; base, ready, waits from midrange register
// - midrange enabled only after both midrange and auxiliary registers accessed
// - midrange asserts with multiplexed phase; non-multiplexed decode lags
// - peripheral base in memory outside other regions or I/O; select four hidden
// - peripheral register gives base, ready and waits for selects zero to three
// - auxiliary bit turns selects six and five into latched address bits
// - auxiliary picks space, ready and waits for selects six and five
// - peripheral selects off until peripheral and auxiliary registers both accessed
// - selects six, five: 0-3 waits; zero to three add 5, 7, 9, 15
// - bit 2 external ready, bits 1-0 waits, bit 3 extends peripheral waits
// - internal waits elapse before external ready may end the cycle
// - selects assert for CPU and DMA cycles alike
// - upper and low selects assert with the non-multiplexed address; here both assert on the cycle start edge, without the lagging midrange delay
`ifndef MCSU_REGS_VH
`define MCSU_REGS_VH

// register byte offsets
`define MCSU_OFS_UPPER 8'h00
`define MCSU_OFS_LOW 8'h04
`define MCSU_OFS_MID 8'h08
`define MCSU_OFS_PERIPH 8'h0c
`define MCSU_OFS_AUX 8'h10
`define MCSU_OFS_STATUS 8'h14

// reset values
`define MCSU_UPPER_RST 16'h0007
`define MCSU_CTRL_RST 16'h0000

// common fields of every select control register; bit 3 is a field of the peripheral register only
`define MCSU_WS_HI 1
`define MCSU_WS_LO 0
`define MCSU_RDY_BIT 2
`define MCSU_WSX_BIT 3
// upper and low region size code, 64K shifted left by the code
`define MCSU_SIZE_HI 13
`define MCSU_SIZE_LO 12
// midrange base, address bits 19..13
`define MCSU_MBASE_HI 15
`define MCSU_MBASE_LO 9
// peripheral base, address bits 19..11
`define MCSU_PBASE_HI 15
`define MCSU_PBASE_LO 7
// auxiliary fields
`define MCSU_AUX_IO_BIT 6
`define MCSU_AUX_ADDR_BIT 7
`define MCSU_AUX_MSZ_HI 10
`define MCSU_AUX_MSZ_LO 8
`define MCSU_AUX_NONMUX_BIT 11

// address positions
`define MCSU_A64K_LO 16
`define MCSU_MID_SHIFT 11
`define MCSU_PBLK_HI 10
`define MCSU_PBLK_LO 8

// extended wait-state counts
`define MCSU_WSX0 4'h5
`define MCSU_WSX1 4'h7
`define MCSU_WSX2 4'h9
`define MCSU_WSX3 4'hf

`endif

// File: rtl/mcsu_wait.v
// wait-state counter and ready gate for one bus cycle
`timescale 1ns/1ps
module mcsu_wait
(
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // cycle control
    input wire start_i,
    input wire end_i,
    input wire [3:0] ws_i,
    input wire use_rdy_i,
    input wire rdy_i,
    // completion
    output reg done_o
);
    reg [3:0] cnt_q;
    reg busy_q;

    // internal waits run out first, only then is external ready looked at
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_q <= 4'h0;
            busy_q <= 1'b0;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (start_i)
            begin
                cnt_q <= ws_i;
                busy_q <= 1'b1;
            end
            else if (end_i)
                busy_q <= 1'b0;
            else if (busy_q)
            begin
                if (cnt_q != 4'h0)
                    cnt_q <= cnt_q - 4'h1;
                else if (!use_rdy_i || rdy_i)
                begin
                    done_o <= 1'b1;
                    busy_q <= 1'b0;
                end
            end
        end
    end
endmodule // mcsu_wait

// File: rtl/mcsu_top.v
// memory and peripheral select unit with ahb-lite register slave
`timescale 1ns/1ps
`include "mcsu_regs.vh"
module mcsu_top
(
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // ahb-lite slave
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire hready_i,
    input wire [31:0] hwdata_i,
    output reg [31:0] hrdata_o,
    output reg hreadyout_o,
    output reg hresp_o,
    // bus cycle from cpu or dma
    input wire cycle_start_i,
    input wire cycle_end_i,
    input wire [19:0] cycle_addr_i,
    input wire cycle_io_i,
    input wire ext_ready_i,
    // select outputs, active low
    output reg upper_select_n_o,
    output reg low_select_n_o,
    output reg [3:0] mid_mem_select_n_o,
    output reg [3:0] periph_select_low_n_o,
    output reg periph_select5_n_o,
    output reg periph_select6_n_o,
    // wait and ready report to bus interface
    output reg [3:0] wait_count_o,
    output reg ext_ready_use_o,
    output reg cycle_ready_o
);
    // state registers
    reg [15:0] upper_select_ctrl_q;
    reg [15:0] low_select_ctrl_q;
    reg [15:0] mid_select_ctrl_q;
    reg [15:0] periph_select_ctrl_q;
    reg [15:0] aux_select_ctrl_q;
    reg low_en_q;
    reg mid_touch_q;
    reg periph_touch_q;
    reg aux_touch_q;
    reg wr_pend_q;
    reg [7:0] wr_ofs_q;
    reg [2:0] rdy_sync_q;
    reg rdy_q;
    reg [3:0] mid_late_n_q;
    reg latched_addr_bit_one_q;
    reg latched_addr_bit_two_q;
    reg in_cycle_q;
    reg [3:0] ws_d;
    reg rdy_use_d;
    reg [6:0] psel_d;
    reg [3:0] msel_d;
    reg up_hit_d;
    reg low_hit_d;
    reg [31:0] rd_d;
    reg start_d_q;
    wire done_w;
    wire mid_en_w;
    wire periph_en_w;
    wire ahb_go_w;
    wire [7:0] ofs_w;

    // enable rules: each select group except upper wakes only on an access to its registers
    assign mid_en_w = mid_touch_q & aux_touch_q;
    assign periph_en_w = periph_touch_q & aux_touch_q;
    assign ahb_go_w = hsel_i & hready_i & htrans_i[1];
    assign ofs_w = haddr_i[7:0];

    // read mux for the address phase; unmapped reads return zero
    always @*
    begin
        rd_d = 32'h0000_0000;
        if (ofs_w == `MCSU_OFS_UPPER)
            rd_d = {16'h0000, upper_select_ctrl_q};
        else if (ofs_w == `MCSU_OFS_LOW)
            rd_d = {16'h0000, low_select_ctrl_q};
        else if (ofs_w == `MCSU_OFS_MID)
            rd_d = {16'h0000, mid_select_ctrl_q};
        else if (ofs_w == `MCSU_OFS_PERIPH)
            rd_d = {16'h0000, periph_select_ctrl_q};
        else if (ofs_w == `MCSU_OFS_AUX)
            rd_d = {16'h0000, aux_select_ctrl_q};
        else if (ofs_w == `MCSU_OFS_STATUS)
            rd_d = {28'h000_0000, rdy_q, periph_en_w, mid_en_w, low_en_q};
    end

    // ahb-lite slave: zero wait, always okay, writes land in the data phase
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            hrdata_o <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            wr_pend_q <= 1'b0;
            wr_ofs_q <= 8'h00;
            upper_select_ctrl_q <= `MCSU_UPPER_RST;
            low_select_ctrl_q <= `MCSU_CTRL_RST;
            mid_select_ctrl_q <= `MCSU_CTRL_RST;
            periph_select_ctrl_q <= `MCSU_CTRL_RST;
            aux_select_ctrl_q <= `MCSU_CTRL_RST;
            low_en_q <= 1'b0;
            mid_touch_q <= 1'b0;
            periph_touch_q <= 1'b0;
            aux_touch_q <= 1'b0;
        end
        else
        begin
            wr_pend_q <= ahb_go_w & hwrite_i;
            if (ahb_go_w)
            begin
                wr_ofs_q <= ofs_w;
                hrdata_o <= hwrite_i ? 32'h0000_0000 : rd_d;
                // a read touches the register just like a write does
                if (ofs_w == `MCSU_OFS_LOW)
                    low_en_q <= 1'b1;
                if (ofs_w == `MCSU_OFS_MID)
                    mid_touch_q <= 1'b1;
                if (ofs_w == `MCSU_OFS_PERIPH)
                    periph_touch_q <= 1'b1;
                if (ofs_w == `MCSU_OFS_AUX)
                    aux_touch_q <= 1'b1;
            end
            if (wr_pend_q)
            begin
                if (wr_ofs_q == `MCSU_OFS_UPPER)
                    upper_select_ctrl_q <= hwdata_i[15:0];
                else if (wr_ofs_q == `MCSU_OFS_LOW)
                    low_select_ctrl_q <= hwdata_i[15:0];
                else if (wr_ofs_q == `MCSU_OFS_MID)
                    mid_select_ctrl_q <= hwdata_i[15:0];
                else if (wr_ofs_q == `MCSU_OFS_PERIPH)
                    periph_select_ctrl_q <= hwdata_i[15:0];
                else if (wr_ofs_q == `MCSU_OFS_AUX)
                    aux_select_ctrl_q <= hwdata_i[15:0];
            end
        end
    end

    // external ready pin: three stages, a change counts once stages two and three agree
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdy_sync_q <= 3'h0;
            rdy_q <= 1'b0;
        end
        else
        begin
            rdy_sync_q <= {rdy_sync_q[1:0], ext_ready_i};
            if (rdy_sync_q[1] == rdy_sync_q[2])
                rdy_q <= rdy_sync_q[2];
        end
    end

    // extended wait translation for peripheral selects zero to four
    function [3:0] pws;
        input [15:0] ctl;
        begin
            if (ctl[`MCSU_WSX_BIT])
            begin
                case (ctl[`MCSU_WS_HI:`MCSU_WS_LO])
                    2'h0: pws = `MCSU_WSX0;
                    2'h1: pws = `MCSU_WSX1;
                    2'h2: pws = `MCSU_WSX2;
                    default: pws = `MCSU_WSX3;
                endcase
            end
            else
                pws = {2'h0, ctl[`MCSU_WS_HI:`MCSU_WS_LO]};
        end
    endfunction

    // region decode; cpu and dma cycles are not told apart here
    always @*
    begin : decode
        reg [1:0] usz;
        reg [1:0] lsz;
        reg [2:0] msz;
        reg [6:0] mmask;
        reg [19:0] moff;
        reg pspace;
        reg phit;
        usz = upper_select_ctrl_q[`MCSU_SIZE_HI:`MCSU_SIZE_LO];
        lsz = low_select_ctrl_q[`MCSU_SIZE_HI:`MCSU_SIZE_LO];
        msz = aux_select_ctrl_q[`MCSU_AUX_MSZ_HI:`MCSU_AUX_MSZ_LO];
        mmask = ~((7'h01 << msz) - 7'h01);
        moff = cycle_addr_i >> (`MCSU_MID_SHIFT + msz);
        pspace = aux_select_ctrl_q[`MCSU_AUX_IO_BIT];
        psel_d = 7'h00;
        msel_d = 4'h0;
        ws_d = 4'h0;
        rdy_use_d = 1'b0;
        // upper region always ends at the top of memory
        up_hit_d = !cycle_io_i && (cycle_addr_i[19:`MCSU_A64K_LO] >=
            (4'h0 - (4'h1 << usz)));
        low_hit_d = low_en_q && !cycle_io_i &&
            (cycle_addr_i[19:`MCSU_A64K_LO] < (4'h1 << lsz));
        phit = periph_en_w && (cycle_io_i == pspace) &&
            (cycle_addr_i[19:`MCSU_PBLK_HI + 1] ==
            periph_select_ctrl_q[`MCSU_PBASE_HI:`MCSU_PBASE_LO]);
        if (up_hit_d)
        begin
            ws_d = {2'h0, upper_select_ctrl_q[`MCSU_WS_HI:`MCSU_WS_LO]};
            rdy_use_d = upper_select_ctrl_q[`MCSU_RDY_BIT];
            low_hit_d = 1'b0;
        end
        else if (low_hit_d)
        begin
            ws_d = {2'h0, low_select_ctrl_q[`MCSU_WS_HI:`MCSU_WS_LO]};
            rdy_use_d = low_select_ctrl_q[`MCSU_RDY_BIT];
        end
        else if (phit && !pspace) // memory-mapped peripherals win over the midrange block
            psel_d[cycle_addr_i[`MCSU_PBLK_HI:`MCSU_PBLK_LO]] = 1'b1;
        else if (mid_en_w && !cycle_io_i && ((cycle_addr_i[19:13] & mmask) ==
            (mid_select_ctrl_q[`MCSU_MBASE_HI:`MCSU_MBASE_LO] & mmask)))
        begin
            msel_d[moff[1:0]] = 1'b1;
            ws_d = {2'h0, mid_select_ctrl_q[`MCSU_WS_HI:`MCSU_WS_LO]};
            rdy_use_d = mid_select_ctrl_q[`MCSU_RDY_BIT];
        end
        else if (phit)
            psel_d[cycle_addr_i[`MCSU_PBLK_HI:`MCSU_PBLK_LO]] = 1'b1;
        // peripheral waits; select four still waits though it has no pin
        if (psel_d[4:0] != 5'h00)
        begin
            ws_d = pws(periph_select_ctrl_q);
            rdy_use_d = periph_select_ctrl_q[`MCSU_RDY_BIT];
        end
        else if (psel_d[6:5] != 2'h0 && aux_select_ctrl_q[`MCSU_AUX_ADDR_BIT])
            psel_d[6:5] = 2'h0;
        else if (psel_d[6:5] != 2'h0)
        begin
            ws_d = {2'h0, aux_select_ctrl_q[`MCSU_WS_HI:`MCSU_WS_LO]};
            rdy_use_d = aux_select_ctrl_q[`MCSU_RDY_BIT];
        end
    end

    // select outputs: asserted on the cycle start edge, lagging midrange one edge later, released at cycle end
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            upper_select_n_o <= 1'b1;
            low_select_n_o <= 1'b1;
            mid_mem_select_n_o <= 4'hf;
            mid_late_n_q <= 4'hf;
            periph_select_low_n_o <= 4'hf;
            periph_select5_n_o <= 1'b1;
            periph_select6_n_o <= 1'b1;
            latched_addr_bit_one_q <= 1'b0;
            latched_addr_bit_two_q <= 1'b0;
            wait_count_o <= 4'h0;
            ext_ready_use_o <= 1'b0;
            in_cycle_q <= 1'b0;
            start_d_q <= 1'b0;
        end
        else
        begin
            start_d_q <= cycle_start_i;
            if (cycle_start_i)
            begin
                in_cycle_q <= 1'b1;
                upper_select_n_o <= ~up_hit_d;
                low_select_n_o <= ~low_hit_d;
                mid_late_n_q <= ~msel_d;
                periph_select_low_n_o <= ~psel_d[3:0];
                latched_addr_bit_one_q <= cycle_addr_i[1];
                latched_addr_bit_two_q <= cycle_addr_i[2];
                wait_count_o <= ws_d;
                ext_ready_use_o <= rdy_use_d;
                if (aux_select_ctrl_q[`MCSU_AUX_ADDR_BIT])
                begin
                    // pins carry the latched address instead of selects
                    periph_select5_n_o <= cycle_addr_i[1];
                    periph_select6_n_o <= cycle_addr_i[2];
                end
                else
                begin
                    periph_select5_n_o <= ~psel_d[5];
                    periph_select6_n_o <= ~psel_d[6];
                end
                // default timing follows the multiplexed phase, the lagging mode waits
                if (!aux_select_ctrl_q[`MCSU_AUX_NONMUX_BIT])
                    mid_mem_select_n_o <= ~msel_d;
            end
            else if (cycle_end_i)
            begin
                in_cycle_q <= 1'b0;
                upper_select_n_o <= 1'b1;
                low_select_n_o <= 1'b1;
                mid_mem_select_n_o <= 4'hf;
                mid_late_n_q <= 4'hf;
                periph_select_low_n_o <= 4'hf;
                periph_select5_n_o <= aux_select_ctrl_q[`MCSU_AUX_ADDR_BIT] ?
                    latched_addr_bit_one_q : 1'b1;
                periph_select6_n_o <= aux_select_ctrl_q[`MCSU_AUX_ADDR_BIT] ?
                    latched_addr_bit_two_q : 1'b1;
                wait_count_o <= 4'h0;
                ext_ready_use_o <= 1'b0;
            end
            else if (start_d_q && in_cycle_q)
                mid_mem_select_n_o <= mid_late_n_q;
        end
    end

    // wait counter starts when the report becomes valid
    mcsu_wait u_wait
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(start_d_q & in_cycle_q),
        .end_i(cycle_end_i),
        .ws_i(wait_count_o),
        .use_rdy_i(ext_ready_use_o),
        .rdy_i(rdy_q),
        .done_o(done_w)
    );

    // registered completion pulse toward the bus interface
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            cycle_ready_o <= 1'b0;
        else
            cycle_ready_o <= done_w;
    end
endmodule // mcsu_top

// File: test/mcsu_top_sva.sv
// concurrent checks on the ports of the select unit
`timescale 1ns/1ps
module mcsu_top_sva
(
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // bus cycle inputs
    input wire cycle_start_i,
    input wire cycle_end_i,
    input wire [19:0] cycle_addr_i,
    input wire cycle_io_i,
    // select and report outputs
    input wire upper_select_n_o,
    input wire low_select_n_o,
    input wire [3:0] mid_mem_select_n_o,
    input wire [3:0] periph_select_low_n_o,
    input wire [3:0] wait_count_o,
    input wire cycle_ready_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // memory cycle into the top window, which the upper select always covers
    sequence s_top_start;
        cycle_start_i && !cycle_io_i && cycle_addr_i[19:16] == 4'hf;
    endsequence
    // a clean close with no new cycle on the same edge
    sequence s_close;
        cycle_end_i && !cycle_start_i;
    endsequence

    chk_upper_top_hit: assert property (s_top_start |=> !upper_select_n_o)
        else $error("upper select missed a top window cycle");
    chk_io_not_upper: assert property (cycle_start_i && cycle_io_i |=> upper_select_n_o)
        else $error("upper select asserted in an io cycle");
    chk_sel_release: assert property (s_close |=> upper_select_n_o &&
        low_select_n_o && (&mid_mem_select_n_o) && (&periph_select_low_n_o))
        else $error("select still low after cycle end");
    chk_end_no_wait: assert property (s_close |=> wait_count_o == 4'h0)
        else $error("wait report not cleared after cycle end");
    chk_one_sel: assert property ($onehot0(~{upper_select_n_o,
        low_select_n_o, mid_mem_select_n_o, periph_select_low_n_o}))
        else $error("more than one select low");
    chk_ready_min: assert property (cycle_start_i |=> (!cycle_ready_o) [*2])
        else $error("cycle ready came before the waits");
    chk_ready_pulse: assert property (cycle_ready_o |=> !cycle_ready_o)
        else $error("cycle ready longer than one cycle");
    chk_sel_hold: assert property (!cycle_start_i && !cycle_end_i |=>
        $stable({upper_select_n_o, low_select_n_o, periph_select_low_n_o}))
        else $error("select moved inside an open cycle");
endmodule // mcsu_top_sva

bind mcsu_top mcsu_top_sva u_sva
(
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cycle_start_i(cycle_start_i),
    .cycle_end_i(cycle_end_i),
    .cycle_addr_i(cycle_addr_i),
    .cycle_io_i(cycle_io_i),
    .upper_select_n_o(upper_select_n_o),
    .low_select_n_o(low_select_n_o),
    .mid_mem_select_n_o(mid_mem_select_n_o),
    .periph_select_low_n_o(periph_select_low_n_o),
    .wait_count_o(wait_count_o),
    .cycle_ready_o(cycle_ready_o)
);

// File: test/mcsu_mem_model.sv
// far-side memory model answering external ready after a set delay
`timescale 1ns/1ps
module mcsu_mem_model
(
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // selects from the unit and answer delay
    input wire [11:0] sel_n_i,
    input wire [3:0] dly_i,
    // ready pin back to the unit
    output reg ready_o
);
    reg [3:0] cnt_q;

    // ready drops as soon as nothing is selected, so a stale high is never seen
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_q <= 4'h0;
            ready_o <= 1'b0;
        end
        else if (&sel_n_i)
        begin
            cnt_q <= 4'h0;
            ready_o <= 1'b0;
        end
        else
        begin
            cnt_q <= (cnt_q == 4'hf) ? cnt_q : cnt_q + 4'h1;
            ready_o <= (cnt_q >= dly_i);
        end
    end
endmodule // mcsu_mem_model

// File: test/mcsu_top_tb.sv
// self-checking bench for the memory and peripheral select unit
`timescale 1ns/1ps
`include "mcsu_regs.vh"
module mcsu_top_tb;
    reg clk_i;
    reg rst_i;
    reg hsel_i;
    reg [31:0] haddr_i;
    reg [1:0] htrans_i;
    reg hwrite_i;
    reg [31:0] hwdata_i;
    reg cycle_start_i;
    reg cycle_end_i;
    reg [19:0] cycle_addr_i;
    reg cycle_io_i;
    reg [3:0] dly;
    reg [31:0] rd;
    wire [31:0] hrdata_o;
    wire hreadyout_o;
    wire hresp_w;
    wire rdy_ext;
    wire [11:0] sel_w;
    wire [3:0] wait_w;
    wire use_w;
    wire rdy_w;
    integer error_cnt;
    integer check_count;
    integer cyc;
    integer i;
    // extended wait table of the low peripheral selects, code 7 down to 0
    localparam [31:0] WTAB = 32'hf975_3210;

    mcsu_top dut
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .hsel_i(hsel_i),
        .haddr_i(haddr_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hsize_i(3'h2),
        .hready_i(hreadyout_o),
        .hwdata_i(hwdata_i),
        .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_w),
        .cycle_start_i(cycle_start_i),
        .cycle_end_i(cycle_end_i),
        .cycle_addr_i(cycle_addr_i),
        .cycle_io_i(cycle_io_i),
        .ext_ready_i(rdy_ext),
        .upper_select_n_o(sel_w[11]),
        .low_select_n_o(sel_w[10]),
        .mid_mem_select_n_o(sel_w[9:6]),
        .periph_select_low_n_o(sel_w[5:2]),
        .periph_select5_n_o(sel_w[1]),
        .periph_select6_n_o(sel_w[0]),
        .wait_count_o(wait_w),
        .ext_ready_use_o(use_w),
        .cycle_ready_o(rdy_w)
    );

    mcsu_mem_model u_mem
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_n_i(sel_w),
        .dly_i(dly),
        .ready_o(rdy_ext)
    );

    // verdict and end of run
    task end_sim;
    begin
        if (error_cnt == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask

    // compare one value and count it
    task cmp(input [31:0] got, input [31:0] exp);
    begin
        check_count = check_count + 1;
        if (got !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask

    // single word transfer, address phase then data phase, each held until hready
    task ahb(input w, input [7:0] a, input [31:0] wd);
    begin
        @(posedge clk_i);
        hsel_i <= 1'b1;
        htrans_i <= 2'b10;
        haddr_i <= {24'h00_0000, a};
        hwrite_i <= w;
        @(posedge clk_i);
        while (hreadyout_o !== 1'b1) @(posedge clk_i);
        hsel_i <= 1'b0;
        htrans_i <= 2'b00;
        hwdata_i <= wd;
        @(posedge clk_i);
        while (hreadyout_o !== 1'b1) @(posedge clk_i);
        rd = hrdata_o;
    end
    endtask

    // one bus cycle: decode and report, wait length, release at the end
    task bus(input [19:0] a, input io, input [11:0] es, input [3:0] ew, input eu, input ce);
        integer n;
    begin
        @(posedge clk_i);
        cycle_start_i <= 1'b1;
        cycle_addr_i <= a;
        cycle_io_i <= io;
        @(posedge clk_i);
        cycle_start_i <= 1'b0;
        #1;
        cmp({15'h0000, sel_w, wait_w, use_w}, {15'h0000, es, ew, eu});
        n = 0;
        while (rdy_w !== 1'b1 && n < 60)
        begin
            @(posedge clk_i);
            #1;
            n = n + 1;
        end
        cmp({31'h0000_0000, n >= ew + 3 && n < 60}, 32'h0000_0001);
        @(posedge clk_i);
        cycle_end_i <= 1'b1;
        @(posedge clk_i);
        cycle_end_i <= 1'b0;
        #1;
        if (ce)
            cmp({16'h0000, sel_w, wait_w}, 32'h0000_fff0);
    end
    endtask

    // reset state: upper window live with three waits and ready, others off
    task t_reset;
    begin
        ahb(1'b0, `MCSU_OFS_UPPER, 32'h0000_0000);
        cmp(rd, 32'h0000_0007);
        ahb(1'b0, `MCSU_OFS_STATUS, 32'h0000_0000);
        cmp(rd, 32'h0000_0000);
        ahb(1'b0, 8'h18, 32'h0000_0000);
        cmp(rd, 32'h0000_0000);
        cmp({31'h0000_0000, hresp_w}, 32'h0000_0000);
        bus(20'hffff0, 1'b0, 12'h7ff, 4'h3, 1'b1, 1'b1);
        dly = 4'h0;
        bus(20'hf0000, 1'b0, 12'h7ff, 4'h3, 1'b1, 1'b1);
        bus(20'h0fff0, 1'b1, 12'hfff, 4'h0, 1'b0, 1'b1);
    end
    endtask

    // low select off until its register is touched by a read
    task t_low;
    begin
        bus(20'h01000, 1'b0, 12'hfff, 4'h0, 1'b0, 1'b1);
        ahb(1'b0, `MCSU_OFS_LOW, 32'h0000_0000);
        cmp(rd, 32'h0000_0000);
        bus(20'h01000, 1'b0, 12'hbff, 4'h0, 1'b0, 1'b1);
    end
    endtask

    // upper window widened to 128k with one wait and no ready
    task t_upper;
    begin
        ahb(1'b1, `MCSU_OFS_UPPER, 32'h0000_1001);
        bus(20'he0000, 1'b0, 12'h7ff, 4'h1, 1'b0, 1'b1);
        bus(20'hd0000, 1'b0, 12'hfff, 4'h0, 1'b0, 1'b1);
    end
    endtask

    // midrange and peripheral need the auxiliary register touched as well
    task t_mid;
    begin
        ahb(1'b1, `MCSU_OFS_MID, 32'h0000_4002);
        ahb(1'b1, `MCSU_OFS_PERIPH, 32'h0000_8000);
        ahb(1'b0, `MCSU_OFS_STATUS, 32'h0000_0000);
        cmp(rd, 32'h0000_0001);
        bus(20'h40800, 1'b0, 12'hfff, 4'h0, 1'b0, 1'b1);
        ahb(1'b1, `MCSU_OFS_AUX, 32'h0000_0000);
        ahb(1'b0, `MCSU_OFS_STATUS, 32'h0000_0000);
        cmp(rd, 32'h0000_0007);
        bus(20'h40800, 1'b0, 12'hf7f, 4'h2, 1'b0, 1'b1);
        bus(20'h40000, 1'b0, 12'hfbf, 4'h2, 1'b0, 1'b1);
    end
    endtask

    // every wait code of the low peripheral selects, then ready honoured
    task t_periph;
    begin
        for (i = 0; i < 8; i = i + 1)
        begin
            ahb(1'b1, `MCSU_OFS_PERIPH, {16'h0000, 12'h800, i[2], 1'b0, i[1:0]});
            bus(20'h80000, 1'b0, 12'hffb, WTAB[i*4 +: 4], 1'b0, 1'b1);
        end
        ahb(1'b1, `MCSU_OFS_PERIPH, 32'h0000_8004);
        bus(20'h80300, 1'b0, 12'hfdf, 4'h0, 1'b1, 1'b1);
    end
    endtask

    // selects six and five: own waits, then latched address mode
    task t_aux;
    begin
        ahb(1'b1, `MCSU_OFS_AUX, 32'h0000_0003);
        bus(20'h80500, 1'b0, 12'hffd, 4'h3, 1'b0, 1'b1);
        bus(20'h80600, 1'b0, 12'hffe, 4'h3, 1'b0, 1'b1);
        ahb(1'b1, `MCSU_OFS_AUX, 32'h0000_0080);
        bus(20'h00002, 1'b0, 12'hbfe, 4'h0, 1'b0, 1'b0);
        // peripherals moved to io space at base zero, midrange decode lagging
        ahb(1'b1, `MCSU_OFS_PERIPH, 32'h0000_0000);
        ahb(1'b1, `MCSU_OFS_AUX, 32'h0000_0840);
        bus(20'h00100, 1'b1, 12'hff7, 4'h0, 1'b0, 1'b1);
        bus(20'h40800, 1'b0, 12'hfff, 4'h2, 1'b0, 1'b1);
    end
    endtask

    // free-running clock
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // cycle ceiling cuts a hung wait short
    always @(posedge clk_i)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt = error_cnt + 1;
            end_sim;
        end
    end

    // main sequence
    initial
    begin
        error_cnt = 0;
        check_count = 0;
        cyc = 0;
        rst_i = 1'b1;
        hsel_i = 1'b0;
        haddr_i = 32'h0000_0000;
        htrans_i = 2'b00;
        hwrite_i = 1'b0;
        hwdata_i = 32'h0000_0000;
        cycle_start_i = 1'b0;
        cycle_end_i = 1'b0;
        cycle_addr_i = 20'h0_0000;
        cycle_io_i = 1'b0;
        dly = 4'h5;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_low;
        t_upper;
        t_mid;
        t_periph;
        t_aux;
        end_sim;
    end
endmodule // mcsu_top_tb
